// >>> bench/eeb_asserts.sv
/*
 * Checker for the two-wire link between the master and EEPROM ends.
 * Assumes the bench instantiates it beside the interface instance.
 */
`timescale 1ns/1ps
`default_nettype none

module eeb_asserts #(
  parameter int PROG_CYC = 3000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Link and status
  input wire logic scl,
  input wire logic sda,
  input wire logic ssda_oe,
  input wire logic prog_busy
);
  // ************
  // Helpers
  // ************
  int         busy_r;
  int         busy_nxt;
  logic [7:0] per_r;
  logic [7:0] per_nxt;
  logic       scl_r;

  // The period counter saturates so a long idle gap never wraps round.
  always_comb begin
    busy_nxt = prog_busy ? busy_r + 1 : 0;
    per_nxt  = (scl && !scl_r) ? 8'h00 : per_r + {7'h00, per_r != 8'hff};
  end

  always_ff @(posedge sys_clk) begin
    busy_r <= sys_rst ? 0 : busy_nxt;
    per_r  <= sys_rst ? 8'hff : per_nxt;
    scl_r  <= sys_rst ? 1'b1 : scl;
  end

  // ************
  // Properties
  // ************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_idle;
    scl && sda;
  endsequence
  sequence s_held;
    ssda_oe [*8];
  endsequence

  property p_busy_quiet;
    prog_busy |-> !ssda_oe;
  endproperty
  property p_busy_max;
    prog_busy |-> busy_r < PROG_CYC;
  endproperty
  property p_busy_min;
    $fell(prog_busy) |-> busy_r >= PROG_CYC - 1;
  endproperty
  property p_busy_entry;
    $rose(prog_busy) |-> s_idle;
  endproperty
  property p_oe_rise;
    $rose(ssda_oe) |-> !scl;
  endproperty
  property p_oe_fall;
    $fell(ssda_oe) |-> !scl;
  endproperty
  property p_oe_hold;
    $rose(ssda_oe) |-> s_held;
  endproperty
  property p_scl_rate;
    $rose(scl) |-> per_r >= 8'd124;
  endproperty

  a_busy_quiet: assert property (p_busy_quiet)
    else $error("data driven while busy");
  a_busy_max: assert property (p_busy_max)
    else $error("program cycle too long");
  a_busy_min: assert property (p_busy_min)
    else $error("program cycle too short");
  a_busy_entry: assert property (p_busy_entry)
    else $error("busy began on an active bus");
  a_oe_rise: assert property (p_oe_rise)
    else $error("data pulled while clock high");
  a_oe_fall: assert property (p_oe_fall)
    else $error("data released while clock high");
  a_oe_hold: assert property (p_oe_hold)
    else $error("data low pulse too short");
  a_scl_rate: assert property (p_scl_rate)
    else $error("clock period too short");
endmodule

`default_nettype wire

// >>> bench/serial_eeprom_bus_slave_bench.sv
/*
 * Bench joining the master and EEPROM ends over one link.
 * Assumes the design files and eeb_asserts are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_bus_slave_bench;
  // The program cycle is shortened so polling ends within the run.
  localparam int PCYC = 3000;
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       strap_select_pin = 1'b1;
  logic       cmd_valid = 1'b0;
  logic       cmd_read = 1'b0;
  logic       cmd_strap = 1'b0;
  logic [9:0] cmd_addr = 10'h000;
  logic [4:0] cmd_len = 5'h01;
  logic       wr_valid = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic       rd_ready = 1'b0;
  logic       cmd_ready, wr_ready, rd_valid, done, nack, prog_busy;
  logic [7:0] rd_data;
  logic [7:0] wq[$];
  logic [7:0] rq[$];
  int         num_errors = 0;
  int         total_checks = 0;
  int         k;

  always #10 sys_clk = ~sys_clk;

  // ************
  // Instances
  // ************
  eeb_if bus_if ();
  eeb_dev #(.PROG_CYC(PCYC)) eeb_dev_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus_if),
    .strap_select_pin(strap_select_pin), .prog_busy(prog_busy));
  eeb_mst #(.KHZ(400)) eeb_mst_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus_if),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
    .cmd_strap(cmd_strap), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .done(done), .nack(nack));
  eeb_asserts #(.PROG_CYC(PCYC)) eeb_asserts_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .scl(bus_if.scl),
    .sda(bus_if.sda), .ssda_oe(bus_if.ssda_oe), .prog_busy(prog_busy));

  // ************
  // Tasks
  // ************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Holding the reader off past two bytes makes the master stall the clock.
  task automatic xfer(input logic rd, input logic st, input logic [9:0] a,
                      input logic [4:0] n, input int stall);
    int i;
    bit got;
    got = 1'b0;
    rq.delete();
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_read  = rd;
    cmd_strap = st;
    cmd_addr  = a;
    cmd_len   = n;
    rd_ready  = stall == 0;
    for (i = 0; i < 60000; i++) begin
      @(posedge sys_clk);
      if (wr_valid && wr_ready) void'(wq.pop_front());
      if (rd_valid && rd_ready) rq.push_back(rd_data);
      if (got && done === 1'b1) break;
      if (cmd_valid && cmd_ready) got = 1'b1;
      @(negedge sys_clk);
      cmd_valid = !got;
      wr_valid  = wq.size() > 0;
      wr_data   = wr_valid ? wq[0] : 8'h00;
      rd_ready  = i >= stall;
    end
    if (i >= 60000) begin
      num_errors++;
      $display("[ERR] %0t transfer hung", $time);
      complete_run;
    end
    @(negedge sys_clk);
    wr_valid = 1'b0;
    wq.delete();
    rd_ready = 1'b1;
    repeat (3) begin
      @(posedge sys_clk);
      if (rd_valid) rq.push_back(rd_data);
    end
    chk({6'h00, bus_if.scl, bus_if.sda}, 8'h03);
  endtask

  // ************
  // Tests
  // ************
  initial begin
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    for (k = 0; k < 16; k++) wq.push_back(8'h30 + 8'(k * 7));
    xfer(1'b0, 1'b1, 10'h3f8, 5'h10, 0);
    chk({7'h00, nack}, 8'h00);
    repeat (20) @(posedge sys_clk);
    chk({7'h00, prog_busy}, 8'h01);
    $display("page write done");
    xfer(1'b1, 1'b1, 10'h3f0, 5'h10, 7000);
    chk({7'h00, nack}, 8'h01);
    for (k = 0; k < 8 && nack === 1'b1; k++)
      xfer(1'b1, 1'b1, 10'h3f0, 5'h10, 7000);
    chk({7'h00, nack}, 8'h00);
    chk(8'(rq.size()), 8'h10);
    for (k = 0; k < 16; k++)
      chk(rq[k], 8'h30 + 8'((k + 8) % 16 * 7));
    $display("poll and read back done");
    wq.push_back(8'h5a);
    xfer(1'b0, 1'b0, 10'h000, 5'h01, 0);
    chk({7'h00, nack}, 8'h01);
    repeat (20) @(posedge sys_clk);
    chk({7'h00, prog_busy}, 8'h00);
    @(negedge sys_clk);
    strap_select_pin = 1'b0;
    xfer(1'b1, 1'b0, 10'h3f5, 5'h01, 0);
    chk({7'h00, nack}, 8'h00);
    chk(rq[0], 8'h30 + 8'(13 * 7));
    $display("strap select done");
    complete_run;
  end
endmodule

`default_nettype wire

// >>> rtl/eeb_dev.sv
/*
 * EEPROM end of the two-wire bus: 1024 x 8 memory, page writes,
 * self-timed program cycle, acknowledge polling, glitch filter.
 * Assumes the master end drives the serial clock; all bus pins are
 * asynchronous to sys_clk and are synchronised here.
 */
// Operation
// - Program cycle ends within 10 or 15 ms
// - Busy: bus ignored, data released, no acknowledge
// - Strap pin gives chip-select bit; low pins ignored
// - At most 16K bits, two devices per bus
// - Start opens, stop closes, receiver acknowledges bytes
// - Master sends type, strap, block, byte address
// - Page of 16 bytes written in one operation
// - Page blocks of 16 pages, selected by address
// - Suppress input pulses under 100 or 50 ns
// - Master selects page block in slave address
// - Acknowledge only matching four-bit device type
// - Last address bit: one read, zero write
// - Program cycle starts on stop after write
// - Polling: no acknowledge busy, acknowledge when done
`timescale 1ns/1ps
`default_nettype none
`include "eeb_regs.svh"

module eeb_dev import eeb_pkg::*; #(
  parameter logic [3:0] DEV_TYPE = 4'h5, // Arbitrary value.
  parameter bit         LOW_VCC  = 1'b0,
  parameter bit         FAST     = 1'b0,
  parameter int         PROG_CYC = (LOW_VCC ? `EEB_TWR_LOW_MS :
                                    `EEB_TWR_STD_MS) *
                                   `EEB_NS_PER_MS / `EEB_CLK_NS
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Bus
  eeb_if.dev        bus,
  // Strap and status
  input  wire logic strap_select_pin,
  output var  logic prog_busy
);

  localparam int GF_NS  = FAST ? `EEB_GF_FAST_NS : `EEB_GF_STD_NS;
  localparam int GF_CYC = (GF_NS + `EEB_CLK_NS - 1) / `EEB_CLK_NS;
  localparam logic [`EEB_GF_W-1:0] GF_LAST = `EEB_GF_W'(GF_CYC - 1);
  localparam logic [`EEB_TMR_W-1:0] TMR_LAST =
    `EEB_TMR_W'(PROG_CYC - 1);

  // *********************************************************
  // Synchronisers
  // *********************************************************
  logic [2:0] sy1_r;
  logic [2:0] sy2_r;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sy1_r <= 3'h7;
      sy2_r <= 3'h7;
    end else begin
      sy1_r <= {strap_select_pin, bus.scl, bus.sda};
      sy2_r <= sy1_r;
    end
  end

  // *********************************************************
  // Glitch filter
  // *********************************************************
  // A line changes only after its new level held GF_CYC cycles.
  logic [1:0]            flt_r;
  logic [1:0]            flt_nxt;
  logic [1:0]            prv_r;
  logic [`EEB_GF_W-1:0]  gcnt_r [2];
  logic [`EEB_GF_W-1:0]  gcnt_nxt [2];

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      flt_nxt[i]  = flt_r[i];
      gcnt_nxt[i] = '0;
      if (sy2_r[i] != flt_r[i]) begin
        if (gcnt_r[i] == GF_LAST) begin
          flt_nxt[i] = sy2_r[i];
        end else begin
          gcnt_nxt[i] = gcnt_r[i] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flt_r  <= 2'h3;
      prv_r  <= 2'h3;
      gcnt_r <= '{default: '0};
    end else begin
      flt_r  <= flt_nxt;
      prv_r  <= flt_r;
      gcnt_r <= gcnt_nxt;
    end
  end

  logic scl_f;
  logic sda_f;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  assign scl_f = flt_r[1];
  assign sda_f = flt_r[0];
  assign rise  = scl_f & ~prv_r[1];
  assign fall  = ~scl_f & prv_r[1];
  assign start = scl_f & prv_r[1] & prv_r[0] & ~sda_f;
  assign stop  = scl_f & prv_r[1] & ~prv_r[0] & sda_f;

  // *********************************************************
  // Protocol engine
  // *********************************************************
  eeb_dst_t              st_r;
  eeb_dst_t              st_nxt;
  logic [3:0]            bit_r;
  logic [3:0]            bit_nxt;
  logic [7:0]            sh_r;
  logic [7:0]            sh_nxt;
  logic [9:0]            addr_r;
  logic [9:0]            addr_nxt;
  logic                  rw_r;
  logic                  rw_nxt;
  logic                  oe_r;
  logic                  oe_nxt;
  logic [7:0]            pbuf_r [`EEB_PAGE_BYTES];
  logic [7:0]            pbuf_nxt [`EEB_PAGE_BYTES];
  logic [15:0]           dirty_r;
  logic [15:0]           dirty_nxt;
  logic [`EEB_TMR_W-1:0] tmr_r;
  logic [`EEB_TMR_W-1:0] tmr_nxt;
  logic                  busy_r;
  logic [7:0]            mem_r [`EEB_MEM_BYTES];
  logic [9:0]            addr_inc;
  logic [7:0]            rd_cur;
  logic [7:0]            rd_inc;
  logic [2:0]            nbit;
  logic                  match;

  assign addr_inc = addr_r + 1'b1;
  assign rd_cur   = mem_r[addr_r];
  assign rd_inc   = mem_r[addr_inc];
  assign nbit     = 3'h6 - bit_r[2:0];
  assign match    = sh_r[7:4] == DEV_TYPE
                    && sh_r[3] == sy2_r[2];

  always_comb begin
    st_nxt    = st_r;
    bit_nxt   = bit_r;
    sh_nxt    = sh_r;
    addr_nxt  = addr_r;
    rw_nxt    = rw_r;
    oe_nxt    = oe_r;
    pbuf_nxt  = pbuf_r;
    dirty_nxt = dirty_r;
    tmr_nxt   = tmr_r;
    if (st_r == D_BUSY) begin
      // Interface is deaf and the line stays released.
      oe_nxt = 1'b0;
      if (tmr_r == '0) begin
        st_nxt    = D_IDLE;
        dirty_nxt = '0;
      end else begin
        tmr_nxt = tmr_r - 1'b1;
      end
    end else if (start) begin
      // A repeated start abandons any unfinished page write.
      st_nxt    = D_SLA;
      // The clock fall that ends the start wraps this to bit zero.
      bit_nxt   = '1;
      oe_nxt    = 1'b0;
      dirty_nxt = '0;
    end else if (stop) begin
      oe_nxt = 1'b0;
      if (st_r == D_WDATA && dirty_r != '0) begin
        st_nxt  = D_BUSY;
        tmr_nxt = TMR_LAST;
      end else begin
        st_nxt = D_IDLE;
      end
    end else if (rise) begin
      sh_nxt = {sh_r[6:0], sda_f};
    end else if (fall) begin
      if (bit_r == `EEB_LAST_BIT) begin
        bit_nxt = `EEB_ACK_BIT;
        oe_nxt  = 1'b0;
        unique case (st_r)
          D_SLA: begin
            if (match) begin
              oe_nxt         = 1'b1;
              addr_nxt[9:8]  = sh_r[2:1];
              rw_nxt         = sh_r[0];
            end else begin
              st_nxt = D_IDLE;
            end
          end
          D_WADDR: begin
            addr_nxt[7:0] = sh_r;
            oe_nxt        = 1'b1;
          end
          D_WDATA: begin
            pbuf_nxt[addr_r[3:0]]  = sh_r;
            dirty_nxt[addr_r[3:0]] = 1'b1;
            oe_nxt                 = 1'b1;
          end
          D_RDATA, D_IDLE, D_BUSY: begin
          end
        endcase
      end else if (bit_r == `EEB_ACK_BIT) begin
        bit_nxt = '0;
        oe_nxt  = 1'b0;
        unique case (st_r)
          D_SLA: begin
            if (rw_r) begin
              st_nxt = D_RDATA;
              oe_nxt = ~rd_cur[7];
            end else begin
              st_nxt = D_WADDR;
            end
          end
          D_WADDR: st_nxt = D_WDATA;
          D_WDATA: begin
            // The page offset wraps; the page itself never changes.
            addr_nxt[3:0] = addr_r[3:0] + 1'b1;
          end
          D_RDATA: begin
            if (!sh_r[0]) begin
              addr_nxt = addr_inc;
              oe_nxt   = ~rd_inc[7];
            end else begin
              st_nxt = D_IDLE;
            end
          end
          D_IDLE, D_BUSY: begin
          end
        endcase
      end else begin
        bit_nxt = bit_r + 1'b1;
        if (st_r == D_RDATA) begin
          oe_nxt = ~rd_cur[nbit];
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r    <= D_IDLE;
      bit_r   <= '0;
      sh_r    <= '0;
      addr_r  <= '0;
      rw_r    <= 1'b0;
      oe_r    <= 1'b0;
      pbuf_r  <= '{default: '0};
      dirty_r <= '0;
      tmr_r   <= '0;
      busy_r  <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      bit_r   <= bit_nxt;
      sh_r    <= sh_nxt;
      addr_r  <= addr_nxt;
      rw_r    <= rw_nxt;
      oe_r    <= oe_nxt;
      pbuf_r  <= pbuf_nxt;
      dirty_r <= dirty_nxt;
      tmr_r   <= tmr_nxt;
      busy_r  <= st_nxt == D_BUSY;
    end
  end

  // *********************************************************
  // Array commit
  // *********************************************************
  // The dirty bytes of the page land together at the end of the program cycle.
  always_ff @(posedge sys_clk) begin
    if (st_r == D_BUSY && tmr_r == '0) begin
      for (int i = 0; i < `EEB_PAGE_BYTES; i++) begin
        if (dirty_r[i]) begin
          mem_r[{addr_r[9:4], 4'(i)}] <= pbuf_r[i];
        end
      end
    end
  end

  assign bus.ssda_o  = 1'b0;
  assign bus.ssda_oe = oe_r;
  assign prog_busy   = busy_r;

endmodule

`default_nettype wire

// >>> rtl/eeb_if.sv
/*
 * Two-wire bus between the master end and the EEPROM end.
 * Assumes open-drain drivers with a pull-up on both lines.
 */
`timescale 1ns/1ps
`default_nettype none

interface eeb_if;
  logic scl_o;
  logic scl_oe;
  logic msda_o;
  logic msda_oe;
  logic ssda_o;
  logic ssda_oe;
  logic scl;
  logic sda;

  // Pull-up: a line is low only while an enabled driver pulls it low.
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((msda_oe & ~msda_o) | (ssda_oe & ~ssda_o));

  modport mst (
    output scl_o, scl_oe, msda_o, msda_oe,
    input  scl, sda
  );
  modport dev (
    output ssda_o, ssda_oe,
    input  scl, sda
  );
endinterface

`default_nettype wire

// >>> rtl/eeb_mst.sv
/*
 * Master end of the two-wire bus: byte writes, page writes, random
 * and sequential reads, two-entry read buffer with back-pressure.
 * Assumes a pull-up on both lines; makes the serial clock itself.
 */
`timescale 1ns/1ps
`default_nettype none
`include "eeb_regs.svh"

module eeb_mst import eeb_pkg::*; #(
  parameter logic [3:0] DEV_TYPE = 4'h5, // Arbitrary value.
  parameter int         KHZ      = `EEB_KHZ_STD,
  parameter int         QCYC     = (`EEB_NS_PER_KHZ + KHZ * `EEB_CLK_NS
                                    * `EEB_QTR - 1) / (KHZ *
                                    `EEB_CLK_NS * `EEB_QTR)
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Bus
  eeb_if.mst              bus,
  // Command
  input  wire logic       cmd_valid,
  output var  logic       cmd_ready,
  input  wire logic       cmd_read,
  input  wire logic       cmd_strap,
  input  wire logic [9:0] cmd_addr,
  input  wire logic [4:0] cmd_len,
  // Write data
  input  wire logic       wr_valid,
  output var  logic       wr_ready,
  input  wire logic [7:0] wr_data,
  // Read data
  output var  logic       rd_valid,
  input  wire logic       rd_ready,
  output var  logic [7:0] rd_data,
  // Completion
  output var  logic       done,
  output var  logic       nack
);

  localparam logic [9:0] QLAST = 10'(QCYC - 1);

  logic sda_s1_r;
  logic sda_s2_r;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
    end else begin
      sda_s1_r <= bus.sda;
      sda_s2_r <= sda_s1_r;
    end
  end

  // *********************************************************
  // Read buffer
  // *********************************************************
  logic       push;
  logic [7:0] push_d;
  logic       fifo_rdy;
  logic       ov_r;
  logic       ov_nxt;
  logic [7:0] od_r;
  logic [7:0] od_nxt;
  logic       sv_r;
  logic       sv_nxt;
  logic [7:0] sd_r;
  logic [7:0] sd_nxt;

  assign fifo_rdy = ~sv_r;

  always_comb begin
    ov_nxt = ov_r;
    od_nxt = od_r;
    sv_nxt = sv_r;
    sd_nxt = sd_r;
    if (ov_r && rd_ready) begin
      ov_nxt = sv_r;
      od_nxt = sd_r;
      sv_nxt = 1'b0;
    end
    if (push) begin
      if (!ov_nxt) begin
        ov_nxt = 1'b1;
        od_nxt = push_d;
      end else begin
        sv_nxt = 1'b1;
        sd_nxt = push_d;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ov_r <= 1'b0;
      od_r <= '0;
      sv_r <= 1'b0;
      sd_r <= '0;
    end else begin
      ov_r <= ov_nxt;
      od_r <= od_nxt;
      sv_r <= sv_nxt;
      sd_r <= sd_nxt;
    end
  end

  // *********************************************************
  // Sequencer
  // *********************************************************
  // Every bus step is four quarter periods; the clock is held low
  // while waiting for write data or for room in the read buffer.
  eeb_mst_t   st_r,   st_nxt;
  eeb_stg_t   sg_r,   sg_nxt;
  logic [9:0] tick_r, tick_nxt;
  logic [1:0] ph_r,   ph_nxt;
  logic [3:0] bit_r,  bit_nxt;
  logic [8:0] sh_r,   sh_nxt;
  logic [4:0] left_r, left_nxt;
  logic [9:0] addr_r, addr_nxt;
  logic       rd_r,   rd_nxt;
  logic       strap_r, strap_nxt;
  logic       scl_r,  scl_nxt;
  logic       sda_r,  sda_nxt;
  logic       nack_r, nack_nxt;
  logic       done_r, done_nxt;
  logic       crdy_r, crdy_nxt;
  logic       wrdy_r, wrdy_nxt;
  logic       step;
  logic [8:0] sla;

  assign step = tick_r == '0;
  // Type, strap bit, page block, direction, then the ack slot.
  assign sla  = {DEV_TYPE, strap_r, addr_r[9:8],
                 sg_r == SG_SLAR, 1'b1};

  always_comb begin
    st_nxt = st_r; sg_nxt = sg_r; ph_nxt = ph_r;
    tick_nxt = step ? QLAST : tick_r - 1'b1;
    bit_nxt = bit_r; sh_nxt = sh_r; left_nxt = left_r;
    addr_nxt = addr_r; rd_nxt = rd_r; strap_nxt = strap_r;
    scl_nxt = scl_r; sda_nxt = sda_r; nack_nxt = nack_r;
    done_nxt = 1'b0; crdy_nxt = crdy_r; wrdy_nxt = wrdy_r;
    push = 1'b0;
    push_d = sh_r[8:1];
    unique case (st_r)
      M_IDLE: begin
        if (cmd_valid && crdy_r) begin
          crdy_nxt = 1'b0; nack_nxt = 1'b0;
          rd_nxt = cmd_read; strap_nxt = cmd_strap;
          addr_nxt = cmd_addr; left_nxt = cmd_len;
          sg_nxt = SG_SLAW; st_nxt = M_START;
          ph_nxt = '0; tick_nxt = QLAST;
          scl_nxt = 1'b0; sda_nxt = 1'b1;
        end
      end
      M_START: begin
        if (step) begin
          ph_nxt = ph_r + 1'b1;
          unique case (ph_r)
            2'h0: scl_nxt = 1'b1;
            2'h1: sda_nxt = 1'b0;
            2'h2: scl_nxt = 1'b0;
            2'h3: begin
              st_nxt = M_BYTE; sh_nxt = sla; bit_nxt = '0;
              ph_nxt = '0; sda_nxt = sla[8];
            end
          endcase
        end
      end
      M_BYTE: begin
        if (step) begin
          ph_nxt = ph_r + 1'b1;
          unique case (ph_r)
            2'h0: scl_nxt = 1'b1;
            2'h1: begin
            end
            2'h2: begin
              scl_nxt = 1'b0;
              sh_nxt = {sh_r[7:0], sda_s2_r};
            end
            2'h3: begin
              bit_nxt = bit_r + 1'b1;
              sda_nxt = sh_r[8];
              if (bit_r == `EEB_ACK_BIT) begin
                sda_nxt = 1'b1;
                st_nxt = M_STOP;
                if (sg_r == SG_RDAT) begin
                  push = 1'b1;
                  left_nxt = left_r - 1'b1;
                  if (left_r != 5'h01) st_nxt = M_RDWAIT;
                end else if (sh_r[0]) begin
                  nack_nxt = 1'b1;
                end else begin
                  unique case (sg_r)
                    SG_SLAW: begin
                      sg_nxt = SG_BADR; st_nxt = M_BYTE;
                      sh_nxt = {addr_r[7:0], 1'b1};
                      bit_nxt = '0; sda_nxt = addr_r[7];
                    end
                    SG_BADR: begin
                      sg_nxt = rd_r ? SG_SLAR : SG_WDAT;
                      st_nxt = rd_r ? M_START : M_WDWAIT;
                      wrdy_nxt = ~rd_r;
                      // Data must be high before a repeated start.
                      sda_nxt = 1'b1;
                    end
                    SG_WDAT: begin
                      left_nxt = left_r - 1'b1;
                      if (left_r != 5'h01) begin
                        st_nxt = M_WDWAIT; wrdy_nxt = 1'b1;
                      end
                    end
                    SG_SLAR: begin
                      sg_nxt = SG_RDAT; st_nxt = M_RDWAIT;
                    end
                    SG_RDAT: begin
                    end
                  endcase
                end
                if (st_nxt == M_STOP) sda_nxt = 1'b0;
              end
            end
          endcase
        end
      end
      M_WDWAIT: begin
        tick_nxt = QLAST; ph_nxt = '0;
        if (wr_valid && wrdy_r) begin
          wrdy_nxt = 1'b0; st_nxt = M_BYTE; bit_nxt = '0;
          sh_nxt = {wr_data, 1'b1}; sda_nxt = wr_data[7];
        end
      end
      M_RDWAIT: begin
        tick_nxt = QLAST; ph_nxt = '0;
        if (fifo_rdy) begin
          // Release data; acknowledge all but the last byte.
          st_nxt = M_BYTE; bit_nxt = '0; sda_nxt = 1'b1;
          sh_nxt = {8'hff, left_r == 5'h01};
        end
      end
      M_STOP: begin
        if (step) begin
          ph_nxt = ph_r + 1'b1;
          unique case (ph_r)
            2'h0: scl_nxt = 1'b1;
            2'h1: sda_nxt = 1'b1;
            2'h2: begin
            end
            2'h3: begin
              st_nxt = M_IDLE; done_nxt = 1'b1; crdy_nxt = 1'b1;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r <= M_IDLE; sg_r <= SG_SLAW; tick_r <= '0; ph_r <= '0;
      bit_r <= '0; sh_r <= '0; left_r <= '0; addr_r <= '0;
      rd_r <= 1'b0; strap_r <= 1'b0; scl_r <= 1'b1; sda_r <= 1'b1;
      nack_r <= 1'b0; done_r <= 1'b0; crdy_r <= 1'b1;
      wrdy_r <= 1'b0;
    end else begin
      st_r <= st_nxt; sg_r <= sg_nxt; tick_r <= tick_nxt;
      ph_r <= ph_nxt; bit_r <= bit_nxt; sh_r <= sh_nxt;
      left_r <= left_nxt; addr_r <= addr_nxt; rd_r <= rd_nxt;
      strap_r <= strap_nxt; scl_r <= scl_nxt; sda_r <= sda_nxt;
      nack_r <= nack_nxt; done_r <= done_nxt; crdy_r <= crdy_nxt;
      wrdy_r <= wrdy_nxt;
    end
  end

  assign bus.scl_o   = 1'b0;
  assign bus.scl_oe  = ~scl_r;
  assign bus.msda_o  = 1'b0;
  assign bus.msda_oe = ~sda_r;
  assign cmd_ready   = crdy_r;
  assign wr_ready    = wrdy_r;
  assign rd_valid    = ov_r;
  assign rd_data     = od_r;
  assign done        = done_r;
  assign nack        = nack_r;

endmodule

`default_nettype wire

// >>> rtl/eeb_pkg.sv
/*
 * Types shared by both ends of the serial EEPROM bus model.
 * Assumes eeb_regs.svh for the numeric constants.
 */
package eeb_pkg;

  typedef enum logic [2:0] {
    D_IDLE  = 3'h0,
    D_SLA   = 3'h1,
    D_WADDR = 3'h2,
    D_WDATA = 3'h3,
    D_RDATA = 3'h4,
    D_BUSY  = 3'h5
  } eeb_dst_t;

  typedef enum logic [2:0] {
    M_IDLE   = 3'h0,
    M_START  = 3'h1,
    M_BYTE   = 3'h2,
    M_STOP   = 3'h3,
    M_WDWAIT = 3'h4,
    M_RDWAIT = 3'h5
  } eeb_mst_t;

  typedef enum logic [2:0] {
    SG_SLAW = 3'h0,
    SG_BADR = 3'h1,
    SG_WDAT = 3'h2,
    SG_SLAR = 3'h3,
    SG_RDAT = 3'h4
  } eeb_stg_t;

endpackage

// >>> rtl/eeb_regs.svh
/*
 * Constants shared by both ends of the serial EEPROM bus model.
 * Assumes a 50 MHz system clock on both ends.
 */
`ifndef EEB_REGS_SVH
`define EEB_REGS_SVH

// ***********************************************************
// Timing
// ***********************************************************
`define EEB_CLK_NS      20
`define EEB_NS_PER_MS   1000000
`define EEB_TWR_STD_MS  10
`define EEB_TWR_LOW_MS  15
`define EEB_GF_STD_NS   100
`define EEB_GF_FAST_NS  50
`define EEB_KHZ_STD     100
`define EEB_KHZ_FAST    400
`define EEB_NS_PER_KHZ  1000000
`define EEB_QTR         4

// ***********************************************************
// Layout
// ***********************************************************
`define EEB_MEM_BYTES   1024
`define EEB_PAGE_BYTES  16
`define EEB_TMR_W       20
`define EEB_GF_W        4
`define EEB_LAST_BIT    4'h7
`define EEB_ACK_BIT     4'h8

`endif
